// >>> include/bdm_pkg.sv
package bdm_pkg;

    // Data memory geometry
    localparam int BANK_COUNT = 32;
    localparam int BANK_BYTES = 128;
    localparam int CORE_COUNT = 12;
    localparam int SFR_COUNT = 20;
    localparam int GPR_BYTES = 80;
    localparam int COMMON_BYTES = 16;
    localparam int GPR_TOTAL = BANK_COUNT * GPR_BYTES;

    // Offsets inside every bank
    localparam logic [6:0] OFS_INDIRECT0 = 7'h00;
    localparam logic [6:0] OFS_INDIRECT1 = 7'h01;
    localparam logic [6:0] OFS_PC_LOW = 7'h02;
    localparam logic [6:0] OFS_ARITH_FLAGS = 7'h03;
    localparam logic [6:0] OFS_PTR0_LOW = 7'h04;
    localparam logic [6:0] OFS_PTR0_HIGH = 7'h05;
    localparam logic [6:0] OFS_PTR1_LOW = 7'h06;
    localparam logic [6:0] OFS_PTR1_HIGH = 7'h07;
    localparam logic [6:0] OFS_BANK_NUMBER = 7'h08;
    localparam logic [6:0] OFS_ACCUMULATOR = 7'h09;
    localparam logic [6:0] OFS_PC_LATCH = 7'h0a;
    localparam logic [6:0] OFS_INT_CONTROL = 7'h0b;
    localparam logic [6:0] OFS_SFR_FIRST = 7'h0c;
    localparam logic [6:0] OFS_GPR_FIRST = 7'h20;
    localparam logic [6:0] OFS_COMMON_FIRST = 7'h70;

    // Field positions of arith_reset_flags
    localparam int FLAG_EXPIRY_BIT = 4;
    localparam int FLAG_POWER_DOWN_BIT = 3;
    localparam int FLAG_ZERO_BIT = 2;
    localparam int FLAG_NIBBLE_BIT = 1;
    localparam int FLAG_CARRY_BIT = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h18;

    // Field positions of a file_select_pointer
    localparam int PTR_PM_BIT = 15;
    localparam int PTR_SPARE_MSB = 14;
    localparam int PTR_SPARE_LSB = 12;
    localparam int PTR_BANK_MSB = 11;
    localparam int PTR_BANK_LSB = 7;
    localparam int PTR_OFS_MSB = 6;

    // Program memory port
    localparam int PM_ADDR_BITS = 15;
    localparam int PM_WORD_BITS = 14;

    // Operations issued by the instruction execution logic
    typedef enum logic [3:0] {
        OP_READ,
        OP_WRITE,
        OP_CLEAR,
        OP_ADD,
        OP_SUB,
        OP_AND,
        OP_OR,
        OP_XOR,
        OP_ROT_LEFT,
        OP_ROT_RIGHT,
        OP_SWAP,
        OP_BRANCH
    } bdm_op_type;

endpackage : bdm_pkg

// >>> src/bdm_alu.sv
module bdm_alu (
    input wire bdm_pkg::bdm_op_type op_in,
    input wire logic [7:0] src_in,
    input wire logic [7:0] acc_in,
    input wire logic carry_in,
    output logic [7:0] result_out,
    output logic zero_out,
    output logic nibble_out,
    output logic carry_out,
    output logic upd_zero_out,
    output logic upd_nibble_out,
    output logic upd_carry_out
);

    // Sum with carries out of bit 3 and bit 7: {carry, nibble, sum}
    function automatic logic [9:0] add_flags(input logic [7:0] a, input logic [7:0] b,
                                             input logic cin);
        logic [4:0] low;
        logic [8:0] full;
        low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        return {full[8], low[4], full[7:0]};
    endfunction : add_flags

    // Result and flag update masks per operation
    always_comb begin
        logic [9:0] sum;
        sum = 10'h000;
        result_out = src_in;
        nibble_out = 1'b0;
        carry_out = carry_in;
        upd_zero_out = 1'b0;
        upd_nibble_out = 1'b0;
        upd_carry_out = 1'b0;
        unique case (op_in)
            bdm_pkg::OP_ADD: begin
                sum = add_flags(src_in, acc_in, 1'b0);
                result_out = sum[7:0];
                nibble_out = sum[8];
                carry_out = sum[9];
                upd_zero_out = 1'b1;
                upd_nibble_out = 1'b1;
                upd_carry_out = 1'b1;
            end
            bdm_pkg::OP_SUB: begin
                // Two's complement add, so both carries read as not-borrow
                sum = add_flags(src_in, ~acc_in, 1'b1);
                result_out = sum[7:0];
                nibble_out = sum[8];
                carry_out = sum[9];
                upd_zero_out = 1'b1;
                upd_nibble_out = 1'b1;
                upd_carry_out = 1'b1;
            end
            bdm_pkg::OP_AND: begin
                result_out = src_in & acc_in;
                upd_zero_out = 1'b1;
            end
            bdm_pkg::OP_OR: begin
                result_out = src_in | acc_in;
                upd_zero_out = 1'b1;
            end
            bdm_pkg::OP_XOR: begin
                result_out = src_in ^ acc_in;
                upd_zero_out = 1'b1;
            end
            bdm_pkg::OP_CLEAR: begin
                result_out = 8'h00;
                upd_zero_out = 1'b1;
            end
            bdm_pkg::OP_ROT_LEFT: begin
                result_out = {src_in[6:0], carry_in};
                carry_out = src_in[7];
                upd_carry_out = 1'b1;
            end
            bdm_pkg::OP_ROT_RIGHT: begin
                result_out = {carry_in, src_in[7:1]};
                carry_out = src_in[0];
                upd_carry_out = 1'b1;
            end
            bdm_pkg::OP_SWAP: result_out = {src_in[3:0], src_in[7:4]};
            bdm_pkg::OP_WRITE: result_out = acc_in;
            bdm_pkg::OP_READ,
            bdm_pkg::OP_BRANCH: result_out = src_in;
        endcase
        zero_out = (result_out == 8'h00);
    end

endmodule : bdm_alu

// >>> src/bdm_data_memory.sv
// Overview of operation
// - Pointer high byte bit 7 set sends indirect port accesses to program memory.
// - Indirect program memory read gives only low 8 bits of the word.
// - Indirect writes aimed at program memory are dropped.
// - Program memory reads through a pointer take one extra cycle.
// - Data memory is 32 banks of 128 byte addresses.
// - Each bank: 12 core, 20 special, 80 general, 16 common bytes.
// - Core registers sit at the first twelve addresses of every bank.
// - Direct accesses use the bank last written to bank_number_register.
// - Addresses without storage read as zero.
// - All data memory reachable directly and through both pointers.
// - Flag-updating ops writing the flags register keep computed flags, drop data.
// - Watchdog expiry and power down flags ignore instruction writes.
// - Clearing the flags register zeroes top bits, sets zero, keeps others.
// - Flags register bits 7 to 5 always read zero.
// - Expiry flag set by power-up, watchdog kick or sleep; cleared on timeout.
// - Power down flag set by power-up or kick, cleared by sleep.
// - Zero flag follows whether an arithmetic or logic result is zero.
// - Add and subtract update nibble_overflow_flag from carry out of bit 3.
// - Add and subtract update the carry flag from carry out of bit 7.
// - Subtraction adds two's complement, carries act as inverted borrows.
// - Rotates load the carry flag with the bit shifted out.
// - Two 16-bit file_select_pointer registers reach data and program memory.
module bdm_data_memory (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic req_in,
    input wire bdm_pkg::bdm_op_type op_in,
    input wire logic [6:0] file_addr_in,
    input wire logic lit_sel_in,
    input wire logic [7:0] lit_in,
    input wire logic dest_file_in,
    input wire logic wdt_kick_in,
    input wire logic sleep_in,
    input wire logic wdt_timeout_in,
    input wire logic [14:0] pc_in,
    input wire logic [13:0] pm_data_in,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] result_out,
    output logic [7:0] acc_out,
    output logic [7:0] status_out,
    output logic [4:0] bank_out,
    output logic pm_rd_out,
    output logic [14:0] pm_addr_out,
    output logic branch_out,
    output logic [14:0] branch_target_out
);

    typedef enum logic {
        ST_IDLE,
        ST_PM_WAIT
    } bdm_fsm_type;

    typedef struct packed {
        bdm_fsm_type fsm;
        bdm_pkg::bdm_op_type op;
        logic [6:0] addr;
        logic lit_sel;
        logic [7:0] lit;
        logic dest_file;
        logic [4:0] bank;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [7:0] acc;
        logic [6:0] pclath;
        logic [7:0] intcon;
        logic expiry;
        logic power_down;
        logic zero;
        logic nibble;
        logic carry;
        logic done;
        logic [7:0] result;
        logic pm_rd;
        logic [14:0] pm_addr;
        logic branch;
        logic [14:0] target;
    } bdm_state_type;

    bdm_state_type cur;
    bdm_state_type next_cur;

    // General purpose bytes of all banks, and the shared common bytes
    logic [7:0] gpr_mem [bdm_pkg::GPR_TOTAL];
    logic [7:0] com_mem [bdm_pkg::COMMON_BYTES];
    logic gpr_we;
    logic [11:0] gpr_idx;
    logic com_we;
    logic [3:0] com_idx;
    logic [7:0] mem_wdata;

    // Decoded request
    bdm_pkg::bdm_op_type rq_op;
    logic [6:0] rq_addr;
    logic rq_lit_sel;
    logic [7:0] rq_lit;
    logic rq_dest_file;
    logic [15:0] ptr;
    logic tgt_pm;
    logic tgt_none;
    logic [4:0] tgt_bank;
    logic [6:0] tgt_off;
    logic [7:0] rd_val;
    logic [7:0] src;
    logic [7:0] flags_byte;

    logic [7:0] alu_result;
    logic alu_zero;
    logic alu_nibble;
    logic alu_carry;
    logic upd_zero;
    logic upd_nibble;
    logic upd_carry;

    // Flat index of a general purpose byte
    function automatic logic [11:0] gpr_index(input logic [4:0] bank, input logic [6:0] off);
        logic [6:0] rel;
        rel = off - bdm_pkg::OFS_GPR_FIRST;
        return 12'(bank) * 12'(bdm_pkg::GPR_BYTES) + {5'h00, rel};
    endfunction : gpr_index

    // Upper three bits are not stored at all
    assign flags_byte = {3'h0, cur.expiry, cur.power_down, cur.zero, cur.nibble, cur.carry};

    // Select request, resolve pointer and fetch the operand
    always_comb begin
        if (cur.fsm == ST_IDLE) begin
            rq_op = op_in;
            rq_addr = file_addr_in;
            rq_lit_sel = lit_sel_in;
            rq_lit = lit_in;
            rq_dest_file = dest_file_in;
        end else begin
            rq_op = cur.op;
            rq_addr = cur.addr;
            rq_lit_sel = cur.lit_sel;
            rq_lit = cur.lit;
            rq_dest_file = cur.dest_file;
        end
        ptr = (rq_addr == bdm_pkg::OFS_INDIRECT1) ? cur.ptr1 : cur.ptr0;
        if (rq_addr == bdm_pkg::OFS_INDIRECT0 || rq_addr == bdm_pkg::OFS_INDIRECT1) begin
            tgt_pm = ptr[bdm_pkg::PTR_PM_BIT];
            tgt_bank = ptr[bdm_pkg::PTR_BANK_MSB:bdm_pkg::PTR_BANK_LSB];
            tgt_off = ptr[bdm_pkg::PTR_OFS_MSB:0];
            // Pointer at an indirect port itself, or past the banked range, hits nothing
            tgt_none = !tgt_pm
                && (ptr[bdm_pkg::PTR_SPARE_MSB:bdm_pkg::PTR_SPARE_LSB] != 3'h0
                || tgt_off == bdm_pkg::OFS_INDIRECT0 || tgt_off == bdm_pkg::OFS_INDIRECT1);
        end else begin
            tgt_pm = 1'b0;
            tgt_bank = cur.bank;
            tgt_off = rq_addr;
            tgt_none = 1'b0;
        end
        rd_val = 8'h00;
        if (!tgt_none && !tgt_pm) begin
            if (tgt_off >= bdm_pkg::OFS_COMMON_FIRST) begin
                rd_val = com_mem[tgt_off[3:0]];
            end else if (tgt_off >= bdm_pkg::OFS_GPR_FIRST) begin
                rd_val = gpr_mem[gpr_index(tgt_bank, tgt_off)];
            end else begin
                // Core registers mirror into every bank; special area reads zero here
                unique case (tgt_off)
                    bdm_pkg::OFS_PC_LOW: rd_val = pc_in[7:0];
                    bdm_pkg::OFS_ARITH_FLAGS: rd_val = flags_byte;
                    bdm_pkg::OFS_PTR0_LOW: rd_val = cur.ptr0[7:0];
                    bdm_pkg::OFS_PTR0_HIGH: rd_val = cur.ptr0[15:8];
                    bdm_pkg::OFS_PTR1_LOW: rd_val = cur.ptr1[7:0];
                    bdm_pkg::OFS_PTR1_HIGH: rd_val = cur.ptr1[15:8];
                    bdm_pkg::OFS_BANK_NUMBER: rd_val = {3'h0, cur.bank};
                    bdm_pkg::OFS_ACCUMULATOR: rd_val = cur.acc;
                    bdm_pkg::OFS_PC_LATCH: rd_val = {1'b0, cur.pclath};
                    bdm_pkg::OFS_INT_CONTROL: rd_val = cur.intcon;
                    default: rd_val = 8'h00;
                endcase
            end
        end
        if (rq_lit_sel) begin
            src = rq_lit;
        end else if (cur.fsm == ST_PM_WAIT) begin
            src = pm_data_in[7:0];
        end else begin
            src = rd_val;
        end
    end

    bdm_alu u_alu (
        .op_in(rq_op),
        .src_in(src),
        .acc_in(cur.acc),
        .carry_in(cur.carry),
        .result_out(alu_result),
        .zero_out(alu_zero),
        .nibble_out(alu_nibble),
        .carry_out(alu_carry),
        .upd_zero_out(upd_zero),
        .upd_nibble_out(upd_nibble),
        .upd_carry_out(upd_carry)
    );

    // Sequencing, register writes and flag updates
    always_comb begin
        logic needs_read;
        logic to_file;
        logic to_acc;
        logic execute;
        needs_read = !rq_lit_sel && rq_op != bdm_pkg::OP_WRITE
            && rq_op != bdm_pkg::OP_CLEAR && rq_op != bdm_pkg::OP_BRANCH;
        to_file = rq_op == bdm_pkg::OP_WRITE
            || (rq_dest_file && rq_op != bdm_pkg::OP_READ && rq_op != bdm_pkg::OP_BRANCH);
        to_acc = !to_file && rq_op != bdm_pkg::OP_BRANCH;
        execute = 1'b0;
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.pm_rd = 1'b0;
        next_cur.branch = 1'b0;
        gpr_we = 1'b0;
        gpr_idx = gpr_index(tgt_bank, tgt_off);
        com_we = 1'b0;
        com_idx = tgt_off[3:0];
        mem_wdata = alu_result;
        unique case (cur.fsm)
            ST_IDLE: begin
                if (req_in && tgt_pm && needs_read) begin
                    // Fetch the word first; the op completes one cycle later
                    next_cur.fsm = ST_PM_WAIT;
                    next_cur.op = op_in;
                    next_cur.addr = file_addr_in;
                    next_cur.lit_sel = lit_sel_in;
                    next_cur.lit = lit_in;
                    next_cur.dest_file = dest_file_in;
                    next_cur.pm_rd = 1'b1;
                    next_cur.pm_addr = ptr[14:0];
                end else begin
                    execute = req_in;
                end
            end
            ST_PM_WAIT: begin
                next_cur.fsm = ST_IDLE;
                execute = 1'b1;
            end
        endcase
        if (execute) begin
            next_cur.done = 1'b1;
            next_cur.result = alu_result;
            if (rq_op == bdm_pkg::OP_BRANCH) begin
                next_cur.branch = 1'b1;
                next_cur.target = pc_in + {7'h00, cur.acc};
            end
            if (to_acc) begin
                next_cur.acc = alu_result;
            end
            // Program memory and empty targets swallow the write
            if (to_file && !tgt_pm && !tgt_none) begin
                if (tgt_off >= bdm_pkg::OFS_COMMON_FIRST) begin
                    com_we = 1'b1;
                end else if (tgt_off >= bdm_pkg::OFS_GPR_FIRST) begin
                    gpr_we = 1'b1;
                end else begin
                    unique case (tgt_off)
                        bdm_pkg::OFS_ARITH_FLAGS: begin
                            // Computed flags win over a written value
                            if (!(upd_zero || upd_nibble || upd_carry)) begin
                                next_cur.zero = alu_result[bdm_pkg::FLAG_ZERO_BIT];
                                next_cur.nibble = alu_result[bdm_pkg::FLAG_NIBBLE_BIT];
                                next_cur.carry = alu_result[bdm_pkg::FLAG_CARRY_BIT];
                            end
                        end
                        bdm_pkg::OFS_PTR0_LOW: next_cur.ptr0[7:0] = alu_result;
                        bdm_pkg::OFS_PTR0_HIGH: next_cur.ptr0[15:8] = alu_result;
                        bdm_pkg::OFS_PTR1_LOW: next_cur.ptr1[7:0] = alu_result;
                        bdm_pkg::OFS_PTR1_HIGH: next_cur.ptr1[15:8] = alu_result;
                        bdm_pkg::OFS_BANK_NUMBER: next_cur.bank = alu_result[4:0];
                        bdm_pkg::OFS_ACCUMULATOR: next_cur.acc = alu_result;
                        bdm_pkg::OFS_PC_LATCH: next_cur.pclath = alu_result[6:0];
                        bdm_pkg::OFS_INT_CONTROL: next_cur.intcon = alu_result;
                        default: begin
                            // Ports, program counter low byte and special area not held here
                        end
                    endcase
                end
            end
            if (upd_zero) begin
                next_cur.zero = alu_zero;
            end
            if (upd_nibble) begin
                next_cur.nibble = alu_nibble;
            end
            if (upd_carry) begin
                next_cur.carry = alu_carry;
            end
        end
        // Reset-cause flags move only on watchdog and sleep events
        if (wdt_kick_in) begin
            next_cur.expiry = 1'b1;
            next_cur.power_down = 1'b1;
        end
        if (sleep_in) begin
            next_cur.expiry = 1'b1;
            next_cur.power_down = 1'b0;
        end
        if (wdt_timeout_in) begin
            next_cur.expiry = 1'b0;
        end
    end

    // State register; power-up values for the flags
    always_ff @(posedge mclk_in) begin
        if (!rstn_in) begin
            cur <= '0;
            cur.fsm <= ST_IDLE;
            cur.op <= bdm_pkg::OP_READ;
            cur.expiry <= bdm_pkg::FLAGS_RESET[bdm_pkg::FLAG_EXPIRY_BIT];
            cur.power_down <= bdm_pkg::FLAGS_RESET[bdm_pkg::FLAG_POWER_DOWN_BIT];
            cur.zero <= bdm_pkg::FLAGS_RESET[bdm_pkg::FLAG_ZERO_BIT];
            cur.nibble <= bdm_pkg::FLAGS_RESET[bdm_pkg::FLAG_NIBBLE_BIT];
            cur.carry <= bdm_pkg::FLAGS_RESET[bdm_pkg::FLAG_CARRY_BIT];
        end else begin
            cur <= next_cur;
        end
    end

    // RAM is not cleared by reset, like real SRAM
    always_ff @(posedge mclk_in) begin
        if (gpr_we) begin
            gpr_mem[gpr_idx] <= mem_wdata;
        end
        if (com_we) begin
            com_mem[com_idx] <= mem_wdata;
        end
    end

    assign busy_out = (cur.fsm != ST_IDLE);
    assign done_out = cur.done;
    assign result_out = cur.result;
    assign acc_out = cur.acc;
    assign status_out = flags_byte;
    assign bank_out = cur.bank;
    assign pm_rd_out = cur.pm_rd;
    assign pm_addr_out = cur.pm_addr;
    assign branch_out = cur.branch;
    assign branch_target_out = cur.target;

endmodule : bdm_data_memory

// >>> verif/bdm_pm_model.sv
module bdm_pm_model (
    input logic mclk_in,
    input logic pm_rd_out,
    input logic [14:0] pm_addr_out,
    output logic [13:0] pm_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [13:0] last = 14'h0000;
    // Word holds address bits 6 to 0, then their inverse; idle lines show the inverse of the last word
    assign pm_data_in = pm_rd_out ? {pm_addr_out[6:0], ~pm_addr_out[6:0]} : ~last;
    always @(posedge mclk_in) begin
        last <= pm_data_in;
    end
endmodule : bdm_pm_model

// >>> verif/bdm_data_memory_asserts.sv
module bdm_data_memory_asserts (
    input logic mclk_in,
    input logic rstn_in,
    input logic req_in,
    input bdm_pkg::bdm_op_type op_in,
    input logic wdt_kick_in,
    input logic sleep_in,
    input logic wdt_timeout_in,
    input logic [14:0] pc_in,
    input logic busy_out,
    input logic done_out,
    input logic [7:0] acc_out,
    input logic [7:0] status_out,
    input logic [4:0] bank_out,
    input logic pm_rd_out,
    input logic branch_out,
    input logic [14:0] branch_target_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic quiet;
    // Expiry and power down may only move on an event
    assign quiet = !(wdt_kick_in || sleep_in || wdt_timeout_in);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // Fetch: one wait cycle, then completion
    sequence pm_fetch;
        busy_out ##1 (done_out && !busy_out);
    endsequence
    sequence branch_taken;
        req_in && !busy_out && op_in == bdm_pkg::OP_BRANCH;
    endsequence
    top_bits_zero_a: assert property (status_out[7:5] == 3'h0)
        else $error("flag bits 7 to 5 not zero");
    pm_wait_a: assert property (pm_rd_out |-> pm_fetch)
        else $error("program memory read not one cycle longer");
    sleep_flags_a: assert property (
        sleep_in && !wdt_kick_in && !wdt_timeout_in |=> status_out[4:3] == 2'h2)
        else $error("sleep flags wrong");
    kick_flags_a: assert property (
        wdt_kick_in && !sleep_in && !wdt_timeout_in |=> status_out[4:3] == 2'h3)
        else $error("kick flags wrong");
    timeout_flag_a: assert property (wdt_timeout_in |=> !status_out[4])
        else $error("timeout left expiry set");
    flags_locked_a: assert property (quiet |=> $stable(status_out[4:3]))
        else $error("expiry or power down moved");
    bank_hold_a: assert property (!done_out |-> $stable(bank_out))
        else $error("bank changed without an operation");
    branch_sum_a: assert property (branch_taken |=> branch_out && done_out
        && branch_target_out == $past(pc_in) + {7'h00, $past(acc_out)})
        else $error("branch target wrong");
endmodule : bdm_data_memory_asserts

bind bdm_data_memory bdm_data_memory_asserts bdm_data_memory_asserts_inst (.*);

// >>> verif/test_banked_data_memory_status.sv
module test_banked_data_memory_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic req_in = 1'b0;
    bdm_pkg::bdm_op_type op_in = bdm_pkg::OP_READ;
    logic [6:0] file_addr_in = 7'h00;
    logic lit_sel_in = 1'b0;
    logic [7:0] lit_in = 8'h00;
    logic dest_file_in = 1'b0;
    logic wdt_kick_in = 1'b0;
    logic sleep_in = 1'b0;
    logic wdt_timeout_in = 1'b0;
    logic [14:0] pc_in = 15'h0000;
    logic [13:0] pm_data_in;
    logic busy_out, done_out, pm_rd_out, branch_out;
    logic [7:0] result_out, acc_out, status_out;
    logic [4:0] bank_out;
    logic [14:0] pm_addr_out, branch_target_out;
    int errors = 0;
    int n_compared = 0;
    int m[int]; // Model memory; core and common bytes keyed by offset alone

    bdm_data_memory bdm_data_memory_inst (.*);
    bdm_pm_model bdm_pm_model_inst (.*);

    always #12.5 mclk_in = ~mclk_in;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("Compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    function automatic int key(input int t);
        return (t % 128 < 12 || t % 128 > 111) ? t % 128 : t;
    endfunction : key

    // Target of an access: -1 program memory, -2 nothing behind it
    function automatic int tgt(input int a);
        int p;
        if (a > 1) return m[8] * 128 + a;
        p = m[5 + 2 * a] * 256 + m[4 + 2 * a];
        if (p[15]) return -1;
        if (p[14:12] != 0 || p[6:0] < 2) return -2;
        return p;
    endfunction : tgt

    function automatic int rd(input int t);
        if (t < 0 || t % 128 == 2 || (t % 128 > 11 && t % 128 < 32)) return 0;
        return m.exists(key(t)) ? m[key(t)] : 0;
    endfunction : rd

    // Flags register keeps expiry and power down against writes
    function automatic void wr(input int t, input int v);
        if (t < 0 || t % 128 < 3 || (t % 128 > 9 && t % 128 < 32)) return;
        if (t % 128 == 3) m[3] = m[3] & 8'h18 | v & 8'h07;
        else m[key(t)] = v & 8'hff;
    endfunction : wr

    task automatic exec(input int op, input int a, input int ls, input int l, input int d);
        int t, s, r, acc, st, p, cyc, pm, zf, fl, ar, nc, pc;
        t = tgt(a);
        acc = m[9];
        p = a < 2 ? (m[5 + 2 * a] * 256 + m[4 + 2 * a]) % 32768 : 0;
        pm = t == -1 && !ls && (op == 0 || (op > 2 && op < 11));
        s = ls ? l : t == -1 ? p % 2 * 128 + (~p & 127) : rd(t);
        pc = $urandom % 32768;
        r = s;
        case (op)
            bdm_pkg::OP_CLEAR: r = 0;
            bdm_pkg::OP_ADD: r = s + acc;
            bdm_pkg::OP_SUB: r = s + 256 - acc;
            bdm_pkg::OP_AND: r = s & acc;
            bdm_pkg::OP_OR: r = s | acc;
            bdm_pkg::OP_XOR: r = s ^ acc;
            bdm_pkg::OP_ROT_LEFT: r = s * 2 + m[3] % 2;
            bdm_pkg::OP_ROT_RIGHT: r = s / 2 + m[3] % 2 * 128 + s % 2 * 256;
            bdm_pkg::OP_SWAP: r = s % 16 * 16 + s / 16;
            default: ;
        endcase
        zf = op > 1 && op < 8;
        fl = op > 1 && op < 10;
        ar = op == 3 || op == 4;
        nc = op == 4 ? 16 - acc % 16 : acc % 16;
        if (op == 1 || (d && op > 1 && op < 11)) begin
            if (!(fl && t >= 0 && t % 128 == 3)) wr(t, op == 1 ? acc : r);
        end else if (op != 11) begin
            m[9] = r % 256;
        end
        st = m[3];
        if (zf) st = st & 8'hfb | (r % 256 == 0) * 4;
        if (ar) st = st & 8'hfd | (s % 16 + nc) / 16 * 2;
        if (ar || op == 8 || op == 9) st = st & 8'hfe | r / 256 % 2;
        m[3] = st;
        // Request held one cycle, then bounded wait for completion
        @(negedge mclk_in);
        req_in = 1'b1;
        op_in = bdm_pkg::bdm_op_type'(op);
        file_addr_in = a[6:0];
        lit_sel_in = ls[0];
        lit_in = l[7:0];
        dest_file_in = d[0];
        pc_in = pc[14:0];
        @(negedge mclk_in);
        req_in = 1'b0;
        cyc = 1;
        while (done_out !== 1'b1 && cyc < 4) begin
            @(negedge mclk_in);
            cyc++;
        end
        chk("cycles", cyc, pm ? 2 : 1);
        chk("acc", acc_out, m[9]);
        chk("flags", status_out, m[3]);
        chk("bank", bank_out, m[8]);
        if (op == 0) chk("result", result_out, s);
        if (op == 11) chk("target", branch_target_out, (pc + acc) % 32768);
        if (pm) chk("pm addr", pm_addr_out, p);
    endtask : exec

    task automatic lit(input int v);
        exec(bdm_pkg::OP_READ, 0, 1, v & 255, 0);
    endtask : lit

    task automatic put(input int a);
        exec(bdm_pkg::OP_WRITE, a, 0, 0, 1);
    endtask : put

    task automatic ev(input int k, input int sl, input int to);
        @(negedge mclk_in);
        wdt_kick_in = k[0];
        sleep_in = sl[0];
        wdt_timeout_in = to[0];
        @(negedge mclk_in);
        {wdt_kick_in, sleep_in, wdt_timeout_in} = 3'h0;
        if (k) m[3] = m[3] | 8'h18;
        if (sl) m[3] = (m[3] | 8'h10) & 8'hf7;
        if (to) m[3] = m[3] & 8'hef;
        chk("flags", status_out, m[3]);
    endtask : ev

    initial begin
        int b, o;
        b = $urandom(32'h9050);
        for (int i = 4; i < 10; i++) m[i] = 0;
        m[3] = 8'h18;
        repeat (20) @(negedge mclk_in);
        rstn_in = 1'b1;
        chk("flags", status_out, 8'h18);
        for (int i = 0; i < 8; i++) ev(i % 2, i / 2 % 2, i / 4);
        // Random bank and location, read directly and through both pointers
        for (int i = 0; i < 8; i++) begin
            b = $urandom % 32;
            o = 32 + $urandom % 96;
            lit(b);
            put(8);
            lit($urandom);
            put(o);
            exec(bdm_pkg::OP_READ, o, 0, 0, 0);
            lit(b * 128 + o);
            put(4 + i % 2 * 2);
            lit(b / 2);
            put(5 + i % 2 * 2);
            exec(bdm_pkg::OP_READ, i % 2, 0, 0, 0);
            exec(bdm_pkg::OP_READ, 8, 0, 0, 0);
            exec(bdm_pkg::OP_READ, 12 + $urandom % 20, 0, 0, 0);
        end
        // Program memory through each pointer; writes there are dropped
        for (int i = 0; i < 4; i++) begin
            lit($urandom);
            put(4 + i % 2 * 2);
            lit(8'h80 | $urandom % 128);
            put(5 + i % 2 * 2);
            exec(bdm_pkg::OP_READ, i % 2, 0, 0, 0);
            exec(bdm_pkg::OP_ADD, i % 2, 0, 0, 0);
            exec(bdm_pkg::OP_WRITE, i % 2, 0, 0, 1);
            exec(bdm_pkg::OP_READ, i % 2, 0, 0, 0);
        end
        // Clear through branch operations on random literals
        for (int k = 0; k < 60; k++) begin
            lit($urandom);
            exec(bdm_pkg::OP_CLEAR + k % 10, 0, 1, $urandom % 256, 0);
        end
        // Flags register as destination
        lit(8'hff);
        put(3);
        for (int k = 2; k < 11; k++) exec(k, 3, 0, 0, 1);
        tally_and_finish();
    end

    initial begin
        #(25 * 20000);
        errors++;
        tally_and_finish();
    end
endmodule : test_banked_data_memory_status
